//--- bench/ext_bus_if_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Pin relations of the external bus
module ext_bus_chk (
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic manual_rst_i,
	// Watched outputs
	input wire logic per_stb_o,
	input wire logic data_oe_hi_o,
	input wire logic data_oe_lo_o,
	input wire logic rd_n_o,
	input wire logic high_write_strobe_n_o,
	input wire logic low_write_strobe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || manual_rst_i);

	chk_per_two_states: assert property (
		$rose(per_stb_o) |=> per_stb_o ##1 !per_stb_o)
		else $error("peripheral strobe length wrong");
	chk_read_lanes_off: assert property (
		!rd_n_o |-> !data_oe_hi_o && !data_oe_lo_o)
		else $error("lane driven during read");
	chk_read_no_write: assert property (
		!rd_n_o |-> high_write_strobe_n_o && low_write_strobe_n_o)
		else $error("write strobe during read");
	chk_upper_write_lane: assert property (
		!high_write_strobe_n_o |-> data_oe_hi_o)
		else $error("upper strobe without upper lane");
	chk_lower_write_lane: assert property (
		!low_write_strobe_n_o |-> data_oe_lo_o)
		else $error("lower strobe without lower lane");
	chk_upper_after_t1: assert property (
		$fell(high_write_strobe_n_o) |-> $past(data_oe_hi_o))
		else $error("upper strobe before first state");
	chk_lower_after_t1: assert property (
		$fell(low_write_strobe_n_o) |-> $past(data_oe_lo_o))
		else $error("lower strobe before first state");
	chk_read_min_states: assert property (
		$fell(rd_n_o) |=> !rd_n_o)
		else $error("read cycle shorter than two states");
endmodule // ext_bus_chk

bind ext_bus_if ext_bus_chk chk (
	.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
	.per_stb_o(per_stb_o), .data_oe_hi_o(data_oe_hi_o),
	.data_oe_lo_o(data_oe_lo_o), .rd_n_o(rd_n_o),
	.high_write_strobe_n_o(high_write_strobe_n_o),
	.low_write_strobe_n_o(low_write_strobe_n_o)
);
`default_nettype wire

//--- bench/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Byte memory on the external pins
module ext_mem_model (
	// Clock
	input  wire logic        clk_i,
	// Bus pins
	input  wire logic [23:0] addr_i,
	input  wire logic        rd_n_i,
	input  wire logic        hi_wr_n_i,
	input  wire logic        lo_wr_n_i,
	input  wire logic [15:0] data_i,
	output logic      [15:0] data_o,
	output logic             wait_n_o,
	// Behaviour
	input  wire logic        wide_i,
	input  wire logic [3:0]  slow_i
);
	logic [7:0] mem [0:255];
	logic [7:0] a;
	logic [7:0] junk = 8'h3C;
	logic [3:0] wcnt = 4'h0;

	assign a = addr_i[7:0];
	// Released lanes, the low lane of an 8-bit read and the high lane at an odd wide address carry a changing pattern
	assign data_o = rd_n_i ? {junk, ~junk} :
		wide_i ? {a[0] ? junk : mem[a], mem[a | 8'h01]} :
		{mem[a], junk};
	assign wait_n_o = rd_n_i || wcnt >= slow_i;

	always_ff @(posedge clk_i) begin
		junk <= junk + 8'h5B;
		wcnt <= rd_n_i ? 4'h0 : wcnt + 4'(wcnt != 4'hF);
	end

	always_ff @(posedge clk_i) begin
		if (!hi_wr_n_i) begin
			mem[wide_i ? {a[7:1], 1'b0} : a] <= data_i[15:8];
		end
		if (!lo_wr_n_i) begin
			mem[{a[7:1], 1'b1}] <= data_i[7:0];
		end
	end
endmodule // ext_mem_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
	num_errors++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end

module tb;
	logic        clk_i, rst_i, mrst, cyc, stb, wbwe, ack, req, per, we;
	logic        done, pwide, pstb, oe_hi, oe_lo, rd_n, hi_wr_n, lo_wr_n;
	logic        wait_n, wide, pwe;
	logic [1:0]  size;
	logic [3:0]  sel, slow;
	logic [7:0]  adr;
	logic [15:0] prd, din, dout, mdrv, pwdat;
	logic [23:0] addr, pin_addr, paddr;
	logic [40:0] pcap;
	logic [31:0] wdat, rdat, wdata, rdata, q;
	int          num_errors, n_tests, nrd, nhi, nlo, nolo, nfl, nps;

	assign din = {oe_hi ? dout[15:8] : mdrv[15:8],
		oe_lo ? dout[7:0] : mdrv[7:0]};

	ext_bus_if DUT (
		.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(mrst),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(wbwe),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_dat_o(rdat),
		.req_i(req), .req_periph_i(per), .req_we_i(we), .req_size_i(size),
		.req_addr_i(addr), .req_wdata_i(wdata), .done_o(done),
		.rdata_o(rdata), .per_rdata_i(prd), .per_wide_i(pwide),
		.per_stb_o(pstb), .per_we_o(pwe), .per_addr_o(paddr),
		.per_wdata_o(pwdat),
		.addr_o(pin_addr), .data_i(din), .data_o(dout),
		.data_oe_hi_o(oe_hi), .data_oe_lo_o(oe_lo), .rd_n_o(rd_n),
		.high_write_strobe_n_o(hi_wr_n),
		.low_write_strobe_n_o(lo_wr_n),
		.wait_n_i(wait_n)
	);
	ext_mem_model mem (
		.clk_i(clk_i), .addr_i(pin_addr), .rd_n_i(rd_n),
		.hi_wr_n_i(hi_wr_n), .lo_wr_n_i(lo_wr_n), .data_i(din),
		.data_o(mdrv), .wait_n_o(wait_n),
		.wide_i(wide), .slow_i(slow)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic final_report();
		if (num_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ========================================
	// Bus tasks
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wbwe <= w;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			num_errors++;
			final_report();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic cfg(input int ar, input bit w8, s3, pe,
		input logic [1:0] wt);
		logic [7:0]  bw;
		logic [7:0]  bs;
		logic [15:0] wv;
		bw = 8'hFF;
		bs = 8'hFF;
		wv = 16'hFFFF;
		bw[ar] = w8;
		bs[ar] = s3;
		wv[2 * ar +: 2] = wt;
		wb(8'h00, 1'b1, {24'h0, bw});
		wb(8'h04, 1'b1, {24'h0, bs});
		wb(8'h08, 1'b1, {24'h0, wv[15:8]});
		wb(8'h0C, 1'b1, {24'h0, wv[7:0]});
		wb(8'h10, 1'b1, {31'h0, pe});
		wide <= !w8;
	endtask

	task automatic xf(input logic p, w, input logic [1:0] sz,
		input logic [23:0] a, input logic [31:0] d);
		int   k;
		logic pl;
		k = 0;
		pl = 1'b0;
		{nrd, nhi, nlo, nolo, nfl, nps} = '0;
		pcap = '0;
		@(posedge clk_i);
		per <= p;
		we <= w;
		size <= sz;
		addr <= a;
		wdata <= d;
		req <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
			nrd += (rd_n === 1'b0);
			nhi += (hi_wr_n === 1'b0);
			nlo += (lo_wr_n === 1'b0);
			nolo += (oe_lo === 1'b1);
			nps += (pstb === 1'b1);
			nfl += (!pl && (hi_wr_n === 1'b0 || lo_wr_n === 1'b0));
			pl = (hi_wr_n === 1'b0 || lo_wr_n === 1'b0);
			if (pstb === 1'b1) begin
				pcap = {pwe, paddr, pwdat};
			end
		end while (done !== 1'b1 && k < 300);
		if (done !== 1'b1) begin
			num_errors++;
			final_report();
		end
		req <= 1'b0;
		q = rdata;
	endtask

	task automatic tx(input int ar, input bit w8, s3,
		input logic [1:0] wt, sz, input logic [7:0] off,
		input logic [31:0] d);
		int          nc, st;
		bit          hu, lu;
		logic [23:0] a;
		logic [31:0] m;
		a = {ar[2:0], 13'h0, off};
		nc = w8 ? (1 << sz) : (sz == 2'd2 ? 2 : 1);
		st = s3 ? 3 + wt : 2;
		hu = w8 || sz != 2'd0 || !off[0];
		lu = !w8 && (sz != 2'd0 || off[0]);
		m = sz == 2'd0 ? 32'hFF : sz == 2'd1 ? 32'hFFFF : 32'hFFFF_FFFF;
		cfg(ar, w8, s3, 1'b0, wt);
		xf(1'b0, 1'b1, sz, a, d);
		`CHK("hi_wr_cycles", hu ? nc * (st - 1) : 0, nhi)
		`CHK("lo_wr_cycles", lu ? nc * (st - 1) : 0, nlo)
		`CHK("low_lane_oe", lu ? nc * st : 0, nolo)
		`CHK("bus_cycles", nc, nfl)
		xf(1'b0, 1'b0, sz, a, 32'h0);
		`CHK("rd_states", nc * st, nrd)
		`CHK("rdata", d & m, q)
	endtask

	// ========================================
	// Scenarios
	task automatic t_regs();
		for (int i = 0; i < 7; i++) begin
			wb(8'(i * 4), 1'b0, 32'h0);
			`CHK("reg_reset", i < 4 ? 32'hFF : 32'h0, q)
		end
	endtask

	task automatic t_manual();
		cfg(6, 1'b0, 1'b0, 1'b1, 2'd1);
		mrst <= 1'b1;
		repeat (3) @(posedge clk_i);
		mrst <= 1'b0;
		wb(8'h00, 1'b0, 32'h0);
		`CHK("keep_width", 32'hBF, q)
		wb(8'h10, 1'b0, 32'h0);
		`CHK("keep_pin_en", 32'h1, q)
	endtask

	task automatic t_sizes();
		tx(1, 1'b1, 1'b1, 2'd3, 2'd2, 8'h10, 32'hA1B2C3D4);
		tx(0, 1'b0, 1'b0, 2'd3, 2'd2, 8'h20, 32'h0BADF00D);
		tx(3, 1'b1, 1'b0, 2'd1, 2'd1, 8'h51, 32'h1234);
		tx(2, 1'b0, 1'b1, 2'd0, 2'd0, 8'h31, 32'h5E);
		tx(2, 1'b0, 1'b1, 2'd0, 2'd0, 8'h32, 32'hE5);
	endtask

	task automatic t_waits();
		for (int w = 0; w < 4; w++) begin
			tx(5, 1'b0, 1'b1, 2'(w), 2'd1, 8'h60, 32'hC0DE ^ 32'(w));
		end
	endtask

	task automatic t_pinwait();
		tx(4, 1'b0, 1'b1, 2'd0, 2'd0, 8'h40, 32'h77);
		slow <= 4'd3;
		xf(1'b0, 1'b0, 2'd0, 24'h800040, 32'h0);
		`CHK("pin_off", 3, nrd)
		cfg(4, 1'b0, 1'b1, 1'b1, 2'd0);
		xf(1'b0, 1'b0, 2'd0, 24'h800040, 32'h0);
		`CHK("pin_wait", 5, nrd)
		`CHK("pin_data", 32'h77, q)
		cfg(4, 1'b0, 1'b0, 1'b1, 2'd0);
		xf(1'b0, 1'b0, 2'd0, 24'h800040, 32'h0);
		`CHK("two_state", 2, nrd)
		slow <= 4'd0;
	endtask

	task automatic t_periph();
		prd <= 16'hA5C3;
		pwide <= 1'b1;
		xf(1'b1, 1'b0, 2'd1, 24'h000100, 32'h0);
		`CHK("per_states", 2, nps)
		`CHK("per_word", 32'h0000A5C3, q)
		pwide <= 1'b0;
		xf(1'b1, 1'b0, 2'd1, 24'h000100, 32'h0);
		`CHK("per_byte", 32'h000000C3, q)
		xf(1'b1, 1'b1, 2'd1, 24'h000102, 32'h00005A3C);
		`CHK("per_write", ({1'b1, 24'h000102, 16'h5A3C}), pcap)
		`CHK("per_wr_states", 2, nps)
	endtask

	initial begin
		{mrst, cyc, stb, wbwe, req, per, we, pwide, wide} = '0;
		{size, slow, adr, prd, addr, wdat, wdata} = '0;
		{num_errors, n_tests} = '0;
		sel = 4'h1;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_manual();
		t_sizes();
		t_waits();
		t_pinwait();
		t_periph();
		final_report();
	end

	initial begin
		#100000;
		num_errors++;
		final_report();
	end
endmodule // tb
`default_nettype wire

//--- shared/ext_bus_defines.svh
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

// ============================================================
// Register word indices (byte address = 4 * index)
`define AREA_WIDTH_CONFIG_IDX       6'h00
`define AREA_STATE_COUNT_CONFIG_IDX 6'h01
`define WAIT_COUNT_CONFIG_HIGH_IDX  6'h02
`define WAIT_COUNT_CONFIG_LOW_IDX   6'h03
`define BUS_CONTROL_LOW_IDX         6'h04
`define ENGINE_STATUS_IDX           6'h05

// ============================================================
// Power-on reset values
`define AREA_WIDTH_CONFIG_RST       8'hFF
`define AREA_STATE_COUNT_CONFIG_RST 8'hFF
`define WAIT_COUNT_CONFIG_HIGH_RST  8'hFF
`define WAIT_COUNT_CONFIG_LOW_RST   8'hFF
`define BUS_CONTROL_LOW_RST         8'h00

// ============================================================
// Field positions
`define WAIT_PIN_ENABLE_BIT 0
`define STATUS_BUSY_BIT     0
`define AREA_SEL_MSB        23
`define AREA_SEL_LSB        21

`endif

//--- shared/ext_bus_pkg.sv
package ext_bus_pkg;

	// ============================================================
	// Bus cycle states, one clock period each
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_T1   = 3'b001,
		PH_T2   = 3'b010,
		PH_TW   = 3'b011,
		PH_T3   = 3'b100
	} phase_t;

	// ============================================================
	// Access sizes of the internal master
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} size_t;

	// ============================================================
	// Transfer engine
	typedef enum logic [1:0] {
		EN_IDLE = 2'b00,
		EN_EXT  = 2'b01,
		EN_PER  = 2'b10,
		EN_DONE = 2'b11
	} eng_t;

endpackage

//--- verilog/bus_state_seq.sv
`timescale 1ns/1ps
`default_nettype none

module bus_state_seq
	import ext_bus_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Cycle control
	input  wire logic       start_i,
	input  wire logic       three_state_i,
	input  wire logic [1:0] prog_waits_i,
	input  wire logic       pin_wait_en_i,
	input  wire logic       wait_n_i,
	// State
	output phase_t          phase_o,
	output phase_t          next_phase_o,
	output logic            last_o
);

	logic [1:0] wait_cnt;
	logic [1:0] next_wait_cnt;

	// ============================================================
	// Next state
	always_comb begin
		next_phase_o  = phase_o;
		next_wait_cnt = wait_cnt;
		unique case (phase_o)
			PH_IDLE: begin
				if (start_i) begin
					next_phase_o = PH_T1;
				end
			end
			PH_T1: begin
				next_phase_o  = PH_T2;
				next_wait_cnt = three_state_i ? prog_waits_i : 2'h0; // [R12]
			end
			PH_T2, PH_TW: begin
				if (!three_state_i) begin // [R3]
					next_phase_o = start_i ? PH_T1 : PH_IDLE;
				end else if (wait_cnt != 2'h0) begin // [R12] [R17]
					next_phase_o  = PH_TW;
					next_wait_cnt = wait_cnt - 2'h1;
				end else if (pin_wait_en_i && !wait_n_i) begin // [R14] [R11]
					next_phase_o = PH_TW;
				end else begin
					next_phase_o = PH_T3;
				end
			end
			PH_T3: begin
				next_phase_o = start_i ? PH_T1 : PH_IDLE;
			end
			default: begin
				next_phase_o = PH_IDLE;
			end
		endcase
	end

	// Last state of a cycle: T2 of two-state, T3 of three-state
	assign last_o = (phase_o == PH_T2 && !three_state_i) ||
		(phase_o == PH_T3); // [R16] [R17]

	// ============================================================
	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_o  <= PH_IDLE;
			wait_cnt <= 2'h0;
		end else begin
			phase_o  <= next_phase_o;
			wait_cnt <= next_wait_cnt;
		end
	end

endmodule // bus_state_seq

`default_nettype wire

//--- verilog/ext_bus_if.sv
// Operation
// (R1) Peripheral register access: two states, 8/16 bit
// (R2) External access: 8/16 bit, two/three states
// (R3) Waits only in three-state areas
// (R4) 8-bit space: upper lane, byte per cycle
// (R5) 16-bit space: longword becomes two words
// (R6) 16-bit byte: even upper, odd lower lane
// (R7) One read strobe for any lane
// (R8) High/low write strobes follow written lanes
// (R9) Unused lane ignored on read, undriven on write
// (R10) 8-bit area keeps low write strobe high
// (R11) External cycles stretch by program or pin waits
// (R12) Zero to three program waits per area
// (R13) Per-area width, state and wait bits
// (R14) Pin waits follow program waits when enabled
// (R15) Power-on defaults; manual reset keeps settings
// (R16) One clock period is one state
// (R17) States T1, T2, waits, then T3
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.svh"

module ext_bus_if
	import ext_bus_pkg::*;
(
	// Clock and resets
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        manual_rst_i,
	// Wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	// Internal master request
	input  wire logic        req_i,
	input  wire logic        req_periph_i,
	input  wire logic        req_we_i,
	input  wire logic [1:0]  req_size_i,
	input  wire logic [23:0] req_addr_i,
	input  wire logic [31:0] req_wdata_i,
	output logic             done_o,
	output logic [31:0]      rdata_o,
	// On-chip peripheral port
	input  wire logic [15:0] per_rdata_i,
	input  wire logic        per_wide_i,
	output logic             per_stb_o,
	output logic             per_we_o,
	output logic [23:0]      per_addr_o,
	output logic [15:0]      per_wdata_o,
	// External memory pins
	output logic [23:0]      addr_o,
	input  wire logic [15:0] data_i,
	output logic [15:0]      data_o,
	output logic             data_oe_hi_o,
	output logic             data_oe_lo_o,
	output logic             rd_n_o,
	output logic             high_write_strobe_n_o,
	output logic             low_write_strobe_n_o,
	input  wire logic        wait_n_i
);

	// ============================================================
	// Configuration registers
	logic [7:0] area_width_config;
	logic [7:0] area_state_count_config;
	logic [7:0] wait_count_config_high;
	logic [7:0] wait_count_config_low;
	logic [7:0] bus_control_low;
	logic       wait_pin_enable;

	// Transfer state
	eng_t        eng;
	logic        eng_rst;
	logic        cur_we;
	logic        cur_8bit;
	logic        cur_three;
	logic [1:0]  cur_waits;
	logic        cur_byte;
	logic [23:0] cur_addr;
	logic [31:0] cur_wdata;
	logic [1:0]  last_idx;
	logic [1:0]  idx;
	logic [31:0] rd_acc;

	// Sequencer
	phase_t seq_phase;
	phase_t seq_next;
	logic   seq_last;
	logic   seq_start;
	logic   seq_three;
	logic   accept;
	logic   final_cycle;

	// Request decode
	logic [2:0]  req_area;
	logic [15:0] wait_all;
	logic        req_8bit;
	size_t       req_size;
	logic [1:0]  req_last_idx;

	// Per-cycle pin values
	logic        lane_hi;
	logic        lane_lo;
	logic [1:0]  cyc_idx;
	logic [1:0]  cyc_diff;
	logic [4:0]  wr_shift;
	logic [31:0] wr_word;
	logic [23:0] cyc_addr;
	logic [15:0] cyc_data;
	logic        ext_active;
	logic        wr_phase;

	assign eng_rst         = rst_i || manual_rst_i;
	assign wait_pin_enable = bus_control_low[`WAIT_PIN_ENABLE_BIT];

	// ============================================================
	// Wishbone register access
	logic       wb_hit;
	logic [5:0] wb_idx;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_idx = wb_adr_i[7:2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (wb_hit && !wb_we_i) begin
			unique case (wb_idx)
				`AREA_WIDTH_CONFIG_IDX:
					wb_dat_o <= {24'h0, area_width_config};
				`AREA_STATE_COUNT_CONFIG_IDX:
					wb_dat_o <= {24'h0, area_state_count_config};
				`WAIT_COUNT_CONFIG_HIGH_IDX:
					wb_dat_o <= {24'h0, wait_count_config_high};
				`WAIT_COUNT_CONFIG_LOW_IDX:
					wb_dat_o <= {24'h0, wait_count_config_low};
				`BUS_CONTROL_LOW_IDX:
					wb_dat_o <= {24'h0, bus_control_low};
				`ENGINE_STATUS_IDX:
					wb_dat_o <= {30'h0, eng};
				default:
					wb_dat_o <= 32'h0;
			endcase
		end
	end

	// Only the power-on reset clears the settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin // [R15]
			area_width_config       <= `AREA_WIDTH_CONFIG_RST;
			area_state_count_config <= `AREA_STATE_COUNT_CONFIG_RST;
			wait_count_config_high  <= `WAIT_COUNT_CONFIG_HIGH_RST;
			wait_count_config_low   <= `WAIT_COUNT_CONFIG_LOW_RST;
			bus_control_low         <= `BUS_CONTROL_LOW_RST;
		end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i &&
			wb_sel_i[0]) begin
			unique case (wb_idx)
				`AREA_WIDTH_CONFIG_IDX:
					area_width_config <= wb_dat_i[7:0];
				`AREA_STATE_COUNT_CONFIG_IDX:
					area_state_count_config <= wb_dat_i[7:0];
				`WAIT_COUNT_CONFIG_HIGH_IDX:
					wait_count_config_high <= wb_dat_i[7:0];
				`WAIT_COUNT_CONFIG_LOW_IDX:
					wait_count_config_low <= wb_dat_i[7:0];
				`BUS_CONTROL_LOW_IDX:
					bus_control_low <= wb_dat_i[7:0];
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// Area decode of a new request
	assign req_area = req_addr_i[`AREA_SEL_MSB:`AREA_SEL_LSB];
	assign wait_all = {wait_count_config_high, wait_count_config_low};
	assign req_8bit = area_width_config[req_area]; // [R13]
	assign req_size = size_t'(req_size_i);

	always_comb begin
		unique case (req_size)
			SZ_BYTE: req_last_idx = 2'h0;
			SZ_WORD: req_last_idx = req_8bit ? 2'h1 : 2'h0; // [R4] [R5]
			default: req_last_idx = req_8bit ? 2'h3 : 2'h1; // [R4] [R5]
		endcase
	end

	// ============================================================
	// Transfer engine
	assign accept      = (eng == EN_IDLE) && req_i && !done_o;
	assign final_cycle = seq_last && (idx == last_idx);
	// First T1 follows acceptance, once the request is latched
	assign seq_start   = ((eng == EN_EXT || eng == EN_PER) &&
		(seq_phase == PH_IDLE)) || (seq_last && (idx != last_idx));
	assign seq_three   = (eng == EN_EXT) && cur_three; // [R1]

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			eng <= EN_IDLE;
		end else begin
			unique case (eng)
				EN_IDLE: begin
					if (accept) begin
						eng <= req_periph_i ? EN_PER : EN_EXT;
					end
				end
				EN_EXT, EN_PER: begin
					if (final_cycle) begin
						eng <= EN_DONE;
					end
				end
				EN_DONE: begin
					eng <= EN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			cur_we    <= 1'b0;
			cur_8bit  <= 1'b0;
			cur_three <= 1'b0;
			cur_waits <= 2'h0;
			cur_byte  <= 1'b0;
			cur_addr  <= 24'h0;
			cur_wdata <= 32'h0;
			last_idx  <= 2'h0;
		end else if (accept) begin
			cur_we    <= req_we_i;
			cur_8bit  <= req_8bit;
			cur_three <= area_state_count_config[req_area]; // [R2] [R13]
			cur_waits <= wait_all[{req_area, 1'b0} +: 2]; // [R12] [R13]
			cur_byte  <= (req_size == SZ_BYTE);
			cur_addr  <= req_addr_i;
			cur_wdata <= req_wdata_i;
			last_idx  <= req_periph_i ? 2'h0 : req_last_idx;
		end
	end

	always_ff @(posedge clk_i) begin
		if (eng_rst || accept) begin
			idx <= 2'h0;
		end else if (seq_last && !final_cycle) begin
			idx <= idx + 2'h1;
		end
	end

	bus_state_seq u_seq (
		.clk_i         (clk_i),
		.rst_i         (eng_rst),
		.start_i       (seq_start),
		.three_state_i (seq_three),
		.prog_waits_i  (cur_waits),
		.pin_wait_en_i (wait_pin_enable),
		.wait_n_i      (wait_n_i),
		.phase_o       (seq_phase),
		.next_phase_o  (seq_next),
		.last_o        (seq_last)
	);

	// ============================================================
	// Lane and data alignment of the coming cycle
	assign lane_hi = cur_8bit || !cur_byte || !cur_addr[0]; // [R4] [R6]
	assign lane_lo = !cur_8bit && (!cur_byte || cur_addr[0]); // [R6]
	assign cyc_idx  = seq_last ? idx + 2'h1 : idx;
	assign cyc_diff = last_idx - cyc_idx;
	assign wr_shift = cur_8bit ? {cyc_diff, 3'b000} : {cyc_diff[0], 4'b0000};
	assign wr_word = cur_wdata >> wr_shift;

	always_comb begin
		if (cur_8bit) begin // [R4]
			cyc_addr = cur_addr + {22'h0, cyc_idx};
			cyc_data = {wr_word[7:0], 8'h00};
		end else if (cur_byte) begin // [R6]
			cyc_addr = cur_addr;
			cyc_data = {cur_wdata[7:0], cur_wdata[7:0]};
		end else begin // [R5]
			cyc_addr = cur_addr + {21'h0, cyc_idx, 1'b0};
			cyc_data = wr_word[15:0];
		end
	end

	assign ext_active = (eng == EN_EXT) && (seq_next != PH_IDLE);
	assign wr_phase   = ext_active && cur_we && (seq_next != PH_T1);

	// ============================================================
	// External pins
	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			addr_o <= 24'h0;
			data_o <= 16'h0;
		end else if ((eng == EN_EXT) && (seq_next == PH_T1)) begin
			addr_o <= cyc_addr;
			data_o <= cyc_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			rd_n_o                <= 1'b1;
			high_write_strobe_n_o <= 1'b1;
			low_write_strobe_n_o  <= 1'b1;
			data_oe_hi_o          <= 1'b0;
			data_oe_lo_o          <= 1'b0;
		end else begin
			rd_n_o <= !(ext_active && !cur_we); // [R7]
			high_write_strobe_n_o <= !(wr_phase && lane_hi); // [R8]
			low_write_strobe_n_o  <= !(wr_phase && lane_lo); // [R8] [R10]
			data_oe_hi_o <= ext_active && cur_we && lane_hi; // [R9]
			data_oe_lo_o <= ext_active && cur_we && lane_lo; // [R9]
		end
	end

	// ============================================================
	// Peripheral port: one two-state cycle
	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			per_stb_o   <= 1'b0;
			per_we_o    <= 1'b0;
			per_addr_o  <= 24'h0;
			per_wdata_o <= 16'h0;
		end else begin
			per_stb_o   <= (eng == EN_PER) && (seq_next != PH_IDLE); // [R1]
			per_we_o    <= (eng == EN_PER) && cur_we;
			per_addr_o  <= cur_addr;
			per_wdata_o <= cur_wdata[15:0];
		end
	end

	// ============================================================
	// Read data gathering, unused lane dropped
	always_ff @(posedge clk_i) begin
		if (eng_rst || accept) begin
			rd_acc <= 32'h0;
		end else if (seq_last && !cur_we) begin
			if (eng == EN_PER) begin // [R1]
				rd_acc <= per_wide_i ? {16'h0, per_rdata_i} :
					{24'h0, per_rdata_i[7:0]};
			end else if (cur_8bit) begin // [R4] [R9]
				rd_acc <= {rd_acc[23:0], data_i[15:8]};
			end else if (cur_byte) begin // [R6] [R9]
				rd_acc <= {24'h0,
					cur_addr[0] ? data_i[7:0] : data_i[15:8]};
			end else begin // [R5]
				rd_acc <= {rd_acc[15:0], data_i};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			done_o  <= 1'b0;
			rdata_o <= 32'h0;
		end else begin
			done_o <= (eng == EN_DONE);
			if (eng == EN_DONE) begin
				rdata_o <= cur_we ? 32'h0 : rd_acc;
			end
		end
	end

endmodule // ext_bus_if

`default_nettype wire
